/* src/pgc_core.sv */
// Playback gain and output control: digital volume, speaker level controller,
// amplifier power states, output switches and mono capture.
// Assumes samples and the fs strobe come from logic on clock_i; mute_i is a pin.
`timescale 1ns/1ps

module pgc_core
  import pgc_pkg::*;
(
  input  wire logic                clock_i,
  input  wire logic                reset_n_i,
  input  wire logic                enable_i,
  input  wire logic [ADDR_W-1:0]   addr_i,
  input  wire logic [DATA_W-1:0]   wr_data_i,
  input  wire logic                wr_i,
  input  wire logic                rd_i,
  output logic      [DATA_W-1:0]   rd_data_o,
  input  wire logic                mute_i,
  input  wire logic                fs_tick_i,
  input  wire logic [SAMPLE_W-1:0] play_left_i,
  input  wire logic [SAMPLE_W-1:0] play_right_i,
  input  wire logic [SAMPLE_W-1:0] cap_left_i,
  input  wire logic [SAMPLE_W-1:0] cap_right_i,
  output logic      [VOL_W-1:0]    vol_left_o,
  output logic      [VOL_W-1:0]    vol_right_o,
  output logic      [SAMPLE_W-1:0] spk_mono_o,
  output logic      [LIM_W-1:0]    spk_att_o,
  output logic      [SAMPLE_W-1:0] cap_left_o,
  output logic      [SAMPLE_W-1:0] cap_right_o,
  output logic                     right_rec_power_o,
  output pgc_amp_ctrl_t            amp_o,
  output pgc_switch_t              switch_o,
  output logic      [1:0]          hp_mix_count_o
);

  // Magnitude of a signed sample, saturating the most negative value
  function automatic logic [SAMPLE_W-1:0] mag(input logic [SAMPLE_W-1:0] s);
    logic [SAMPLE_W-1:0] neg;
    neg = (~s) + 16'h0001;
    if (!s[SAMPLE_W-1]) begin
      mag = s;
    end else if (neg[SAMPLE_W-1]) begin
      mag = 16'h7FFF;
    end else begin
      mag = neg;
    end
  endfunction

  // Crossing when the sign changes or the sample lands on zero
  function automatic logic crossed(input logic prev_sign, input logic [SAMPLE_W-1:0] s);
    crossed = (s[SAMPLE_W-1] != prev_sign) || (s == 16'h0000);
  endfunction

  // Mute pin synchroniser; only the second stage is read
  logic mute_meta_reg;
  logic mute_reg;
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mute_meta_reg <= 1'b0;
      mute_reg      <= 1'b0;
    end else if (enable_i) begin
      mute_meta_reg <= mute_i;
      mute_reg      <= mute_meta_reg;
    end
  end

  // Register file
  logic [VOL_W-1:0]  vol_wr_reg [2];
  logic [VOL_W-1:0]  vol_wr_next [2];
  logic [7:0]        ctrl_reg, ctrl_next;
  logic [7:0]        path_reg, path_next;
  logic [7:0]        spk_reg, spk_next;
  logic [DATA_W-1:0] rd_data_reg, rd_data_next;
  logic [1:0]        vol_written;
  logic [VOL_W-1:0]  applied [2];
  logic [LIM_W-1:0]  lim_att_reg;
  pgc_lim_state_t    lim_state_reg;

  always_comb begin
    vol_wr_next  = vol_wr_reg;
    ctrl_next    = ctrl_reg;
    path_next    = path_reg;
    spk_next     = spk_reg;
    vol_written  = 2'b00;
    rd_data_next = 8'h00;
    if (wr_i) begin
      unique case (addr_i)
        ADDR_VOL_L: begin
          vol_wr_next[0] = wr_data_i[VOL_W-1:0];
          vol_written[0] = 1'b1;
        end
        ADDR_VOL_R: begin
          vol_wr_next[1] = wr_data_i[VOL_W-1:0];
          vol_written[1] = 1'b1;
        end
        ADDR_CTRL: ctrl_next = {3'h0, wr_data_i[4:0]};
        ADDR_PATH: path_next = wr_data_i;
        ADDR_SPK:  spk_next  = {3'h0, wr_data_i[4:0]};
        default:   ;
      endcase
    end
    // Read data stands in the cycle after the strobe only; unmapped reads zero
    if (rd_i) begin
      unique case (addr_i)
        ADDR_VOL_L:     rd_data_next = {1'b0, vol_wr_reg[0]};
        ADDR_VOL_R:     rd_data_next = {1'b0, vol_wr_reg[1]};
        ADDR_CTRL:      rd_data_next = ctrl_reg;
        ADDR_PATH:      rd_data_next = path_reg;
        ADDR_SPK:       rd_data_next = spk_reg;
        ADDR_APPLIED_L: rd_data_next = {1'b0, applied[0]};
        ADDR_APPLIED_R: rd_data_next = {1'b0, applied[1]};
        ADDR_LIMIT:     rd_data_next = {(lim_state_reg == LIM_INIT), lim_att_reg};
        default:        rd_data_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      vol_wr_reg[0] <= VOL_RST;
      vol_wr_reg[1] <= VOL_RST;
      ctrl_reg      <= CTRL_RST;
      path_reg      <= PATH_RST;
      spk_reg       <= SPK_RST;
      rd_data_reg   <= 8'h00;
    end else if (enable_i) begin
      vol_wr_reg    <= vol_wr_next;
      ctrl_reg      <= ctrl_next;
      path_reg      <= path_next;
      spk_reg       <= spk_next;
      rd_data_reg   <= rd_data_next;
    end
  end

  logic             zc_en;
  logic [12:0]      zc_limit;
  logic [SAMPLE_W-1:0] chan_sample [2];
  assign zc_en          = ctrl_reg[CTRL_ZC_EN];
  assign zc_limit       = zc_timeout(ctrl_reg[CTRL_TM_HI:CTRL_TM_LO], ctrl_reg[CTRL_RATE]);
  assign chan_sample[0] = play_left_i;
  assign chan_sample[1] = play_right_i;

  // Per-channel volume: each side waits for its own crossing or timeout
  for (genvar ch = 0; ch < 2; ch++) begin : g_vol
    logic [VOL_W-1:0] applied_reg, applied_next;
    logic             pend_reg, pend_next;
    logic [12:0]      zc_cnt_reg, zc_cnt_next;
    logic             sign_reg, sign_next;

    always_comb begin
      applied_next = applied_reg;
      pend_next    = pend_reg;
      zc_cnt_next  = zc_cnt_reg;
      sign_next    = sign_reg;
      if (fs_tick_i) begin
        sign_next = chan_sample[ch][SAMPLE_W-1];
      end
      if (vol_written[ch]) begin
        // A fresh write restarts the wait and drops the older pending code
        pend_next   = zc_en;
        zc_cnt_next = 13'h0000;
        if (!zc_en) begin
          applied_next = vol_wr_next[ch];
        end
      end else if (pend_reg && fs_tick_i) begin
        zc_cnt_next = zc_cnt_reg + 13'h0001;
        if (crossed(sign_reg, chan_sample[ch]) || (zc_cnt_next >= zc_limit)) begin
          applied_next = vol_wr_reg[ch];
          pend_next    = 1'b0;
        end
      end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        applied_reg <= VOL_RST;
        pend_reg    <= 1'b0;
        zc_cnt_reg  <= 13'h0000;
        sign_reg    <= 1'b0;
      end else if (enable_i) begin
        applied_reg <= applied_next;
        pend_reg    <= pend_next;
        zc_cnt_reg  <= zc_cnt_next;
        sign_reg    <= sign_next;
      end
    end

    assign applied[ch] = applied_reg;
  end

  // Mono half sum for the speaker path; the extra bit keeps the sum exact
  logic [SAMPLE_W:0]   mono_sum;
  logic [SAMPLE_W-1:0] mono;
  logic [SAMPLE_W-1:0] level;
  logic [3:0]          lim_shift;
  assign mono_sum  = {play_left_i[SAMPLE_W-1], play_left_i}
                   + {play_right_i[SAMPLE_W-1], play_right_i};
  assign mono      = mono_sum[SAMPLE_W:1];
  // Output level estimate: every 12 half-dB steps of cut is about one bit of shift
  assign lim_shift = 4'(lim_att_reg / HALF_DB_PER_SHIFT);
  assign level     = mag(mono) >> lim_shift;

  // Speaker level controller
  pgc_lim_state_t   lim_state_next;
  logic [LIM_W-1:0] lim_att_next;
  logic [12:0]      init_cnt_reg, init_cnt_next;
  logic [12:0]      rec_cnt_reg, rec_cnt_next;
  logic [1:0]       lim_cnt_reg, lim_cnt_next;
  logic             mono_sign_reg, mono_sign_next;
  logic             spk_pw_prev_reg;
  logic             spk_power_rise;
  assign spk_power_rise = spk_reg[SPK_POWER] && !spk_pw_prev_reg;

  always_comb begin
    lim_state_next = lim_state_reg;
    lim_att_next   = lim_att_reg;
    init_cnt_next  = init_cnt_reg;
    rec_cnt_next   = rec_cnt_reg;
    lim_cnt_next   = lim_cnt_reg;
    mono_sign_next = mono_sign_reg;
    if (fs_tick_i) begin
      mono_sign_next = mono[SAMPLE_W-1];
    end
    if (spk_power_rise) begin
      // Speaker power-up restarts the initialising cycle
      lim_state_next = LIM_INIT;
      init_cnt_next  = 13'h0000;
      lim_att_next   = 7'h00;
    end else begin
      unique case (lim_state_reg)
        LIM_INIT: begin
          // Gain stays untouched until the cycle has run its full length
          if (fs_tick_i) begin
            init_cnt_next = init_cnt_reg + 13'h0001;
            if (init_cnt_next >= INIT_FS) begin
              lim_state_next = LIM_RUN;
              rec_cnt_next   = 13'h0000;
              lim_cnt_next   = 2'h0;
            end
          end
        end
        LIM_RUN: begin
          if (fs_tick_i) begin
            if (level > LIM_THRESH) begin
              // Limiting ignores crossings: 0.5 dB every second sample
              rec_cnt_next = 13'h0000;
              lim_cnt_next = lim_cnt_reg + 2'h1;
              if (lim_cnt_next >= LIM_PERIOD_FS) begin
                lim_cnt_next = 2'h0;
                if (lim_att_reg != LIM_MAX) begin
                  lim_att_next = lim_att_reg + 7'h01;
                end
              end
            end else if ((level < REC_THRESH) && (lim_att_reg != 7'h00)) begin
              // Recovery only below the lower level and only while cut remains
              lim_cnt_next = 2'h0;
              if (rec_cnt_reg != REC_LIMIT_FS) begin
                rec_cnt_next = rec_cnt_reg + 13'h0001;
              end
              if ((rec_cnt_next >= REC_PERIOD_FS)
                  && (crossed(mono_sign_reg, mono)
                      || (rec_cnt_next >= REC_LIMIT_FS))) begin
                rec_cnt_next = 13'h0000;
                lim_att_next = (lim_att_reg > 7'h02) ? (lim_att_reg - 7'h02) : 7'h00;
              end
            end else begin
              // Between the two levels the cut and the recovery count hold; the limit count clears
              lim_cnt_next = 2'h0;
            end
          end
        end
        default: lim_state_next = LIM_INIT;
      endcase
    end
  end

  // Chip reset lands in the initialising cycle
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lim_state_reg   <= LIM_INIT;
      lim_att_reg     <= 7'h00;
      init_cnt_reg    <= 13'h0000;
      rec_cnt_reg     <= 13'h0000;
      lim_cnt_reg     <= 2'h0;
      mono_sign_reg   <= 1'b0;
      spk_pw_prev_reg <= 1'b0;
    end else if (enable_i) begin
      lim_state_reg   <= lim_state_next;
      lim_att_reg     <= lim_att_next;
      init_cnt_reg    <= init_cnt_next;
      rec_cnt_reg     <= rec_cnt_next;
      lim_cnt_reg     <= lim_cnt_next;
      mono_sign_reg   <= mono_sign_next;
      spk_pw_prev_reg <= spk_reg[SPK_POWER];
    end
  end

  // Amplifier states and switches
  pgc_amp_ctrl_t amp_next;
  pgc_switch_t   sw_next;
  logic [1:0]    mix_next;
  logic [VOL_W-1:0] vol_out_next [2];

  always_comb begin
    // The synchronised mute overrides every switch; switch_o clears on the third clock edge after the pin rises
    sw_next.line_one = path_reg[PATH_LINE1_SW] && !mute_reg;
    sw_next.line_two = path_reg[PATH_LINE2_SW] && !mute_reg;
    sw_next.hp_play  = path_reg[PATH_HP_PLAY]  && !mute_reg;
    sw_next.hp_mix   = path_reg[PATH_HP_MIX]   && !mute_reg;
    sw_next.tone_hp  = path_reg[PATH_TONE_HP]  && !mute_reg;
    sw_next.limiter  = spk_reg[SPK_LIM_SW]     && !mute_reg;
    sw_next.tone_spk = path_reg[PATH_TONE_SPK] && !mute_reg;
    // Equal weights: the analogue mixer divides by the number of live sources
    mix_next = 2'(sw_next.hp_play) + 2'(sw_next.hp_mix) + 2'(sw_next.tone_hp);

    // Line outputs: no power means Hi-Z, switch off means common in save
    amp_next.line_one = !path_reg[PATH_LINE1_PW] ? AMP_HIZ
                      : sw_next.line_one ? AMP_ACTIVE : AMP_COMMON;
    amp_next.line_two = !path_reg[PATH_LINE2_PW] ? AMP_HIZ
                      : sw_next.line_two ? AMP_ACTIVE : AMP_COMMON;
    // Headphone: powered down pulls low, no source gives common
    amp_next.headphone = !spk_reg[SPK_HP_POWER] ? AMP_LOW
                       : (mix_next != 2'h0) ? AMP_ACTIVE : AMP_COMMON;
    // Speaker: off is Hi-Z, not released is power-save
    amp_next.speaker = !spk_reg[SPK_POWER] ? AMP_HIZ
                     : (!spk_reg[SPK_SAVE_REL] || mute_reg) ? AMP_COMMON : AMP_ACTIVE;
    amp_next.mono_out = !spk_reg[SPK_POWER] ? AMP_HIZ
                      : (!spk_reg[SPK_MONO_OUT] || mute_reg) ? AMP_COMMON : AMP_ACTIVE;

    // Volume codes above the last step all mean mute
    for (int ch = 0; ch < 2; ch++) begin
      vol_out_next[ch] = (applied[ch] > VOL_ATT_MAX) ? VOL_MUTE : applied[ch];
    end
  end

  // Output registers, capture copy and mono speaker sample
  logic [SAMPLE_W-1:0] cap_l_next, cap_r_next, spk_next_s;
  logic                mono_rec;
  assign mono_rec = ctrl_reg[CTRL_MONO_REC];

  always_comb begin
    cap_l_next = cap_left_o;
    cap_r_next = cap_right_o;
    spk_next_s = spk_mono_o;
    if (fs_tick_i) begin
      cap_l_next = cap_left_i;
      cap_r_next = mono_rec ? cap_left_i : cap_right_i;
      spk_next_s = mono;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      vol_left_o        <= VOL_RST;
      vol_right_o       <= VOL_RST;
      spk_mono_o        <= 16'h0000;
      spk_att_o         <= 7'h00;
      cap_left_o        <= 16'h0000;
      cap_right_o       <= 16'h0000;
      right_rec_power_o <= 1'b1;
      amp_o             <= '{AMP_HIZ, AMP_HIZ, AMP_LOW, AMP_HIZ, AMP_HIZ};
      switch_o          <= '0;
      hp_mix_count_o    <= 2'h0;
    end else if (enable_i) begin
      vol_left_o        <= vol_out_next[0];
      vol_right_o       <= vol_out_next[1];
      spk_mono_o        <= spk_next_s;
      spk_att_o         <= lim_att_reg;
      cap_left_o        <= cap_l_next;
      cap_right_o       <= cap_r_next;
      right_rec_power_o <= !mono_rec;
      amp_o             <= amp_next;
      switch_o          <= sw_next;
      hp_mix_count_o    <= mix_next;
    end
  end

  assign rd_data_o = rd_data_reg;

endmodule // pgc_core

/* src/pgc_pkg.sv */
// Constants, types and helpers for the playback gain and output control block.
// Assumes one clock; sample timing arrives as a one-cycle fs strobe on that clock.
package pgc_pkg;

  // Register port geometry
  localparam int unsigned ADDR_W   = 4;
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned SAMPLE_W = 16;
  localparam int unsigned VOL_W    = 7;
  localparam int unsigned LIM_W    = 7;
  localparam int unsigned CNT_W    = 13;

  // Register offsets
  localparam logic [3:0] ADDR_VOL_L     = 4'h0;
  localparam logic [3:0] ADDR_VOL_R     = 4'h1;
  localparam logic [3:0] ADDR_CTRL      = 4'h2;
  localparam logic [3:0] ADDR_PATH      = 4'h3;
  localparam logic [3:0] ADDR_SPK       = 4'h4;
  localparam logic [3:0] ADDR_APPLIED_L = 4'h5;
  localparam logic [3:0] ADDR_APPLIED_R = 4'h6;
  localparam logic [3:0] ADDR_LIMIT     = 4'h7;

  // Control register fields
  localparam int unsigned CTRL_ZC_EN    = 0;
  localparam int unsigned CTRL_TM_LO    = 1;
  localparam int unsigned CTRL_TM_HI    = 2;
  localparam int unsigned CTRL_RATE     = 3;
  localparam int unsigned CTRL_MONO_REC = 4;
  // Path register fields
  localparam int unsigned PATH_LINE1_SW = 0;
  localparam int unsigned PATH_LINE2_SW = 1;
  localparam int unsigned PATH_LINE1_PW = 2;
  localparam int unsigned PATH_LINE2_PW = 3;
  localparam int unsigned PATH_HP_PLAY  = 4;
  localparam int unsigned PATH_HP_MIX   = 5;
  localparam int unsigned PATH_TONE_HP  = 6;
  localparam int unsigned PATH_TONE_SPK = 7;
  // Speaker register fields, and the init flag bit of the limit register
  localparam int unsigned SPK_POWER     = 0;
  localparam int unsigned SPK_SAVE_REL  = 1;
  localparam int unsigned SPK_MONO_OUT  = 2;
  localparam int unsigned SPK_LIM_SW    = 3;
  localparam int unsigned SPK_HP_POWER  = 4;
  localparam int unsigned LIMIT_INIT    = 7;

  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] PATH_RST = 8'h00;
  localparam logic [7:0] SPK_RST  = 8'h00;
  localparam logic [6:0] VOL_RST  = 7'h00;

  // Volume code: 0.75 dB per code, 87 codes reach -65.25 dB, top code is mute
  localparam logic [6:0] VOL_ATT_MAX = 7'h57;
  localparam logic [6:0] VOL_MUTE    = 7'h7F;

  // Level thresholds as sample magnitudes (-6.5 dBV and -8.5 dBV at full scale)
  localparam logic [15:0] LIM_THRESH = 16'h65AC;
  localparam logic [15:0] REC_THRESH = 16'h50C3;
  localparam logic [6:0]  LIM_MAX    = 7'h7F;
  localparam logic [6:0]  HALF_DB_PER_SHIFT = 7'h0C;

  // Timing in sample periods
  localparam logic [12:0] INIT_FS       = 13'h0800;
  localparam logic [12:0] REC_PERIOD_FS = 13'h0800;
  localparam logic [12:0] REC_LIMIT_FS  = 13'h1000;
  localparam logic [1:0]  LIM_PERIOD_FS = 2'h2;
  localparam logic [12:0] ZC_BASE_FS    = 13'h0080;

  // Output amplifier states, one-hot
  typedef enum logic [3:0] {
    AMP_HIZ    = 4'b0001,
    AMP_LOW    = 4'b0010,
    AMP_COMMON = 4'b0100,
    AMP_ACTIVE = 4'b1000
  } pgc_amp_t;

  typedef enum logic [1:0] {
    LIM_INIT = 2'b01,
    LIM_RUN  = 2'b10
  } pgc_lim_state_t;

  typedef struct packed {
    pgc_amp_t line_one;
    pgc_amp_t line_two;
    pgc_amp_t headphone;
    pgc_amp_t speaker;
    pgc_amp_t mono_out;
  } pgc_amp_ctrl_t;

  typedef struct packed {
    logic line_one;
    logic line_two;
    logic hp_play;
    logic hp_mix;
    logic tone_hp;
    logic limiter;
    logic tone_spk;
  } pgc_switch_t;

  // Zero-crossing timeout length in samples from select and rate scale
  function automatic logic [12:0] zc_timeout(input logic [1:0] sel, input logic scale);
    logic [12:0] len;
    len = ZC_BASE_FS << sel;
    zc_timeout = scale ? (len << 1) : len;
  endfunction

endpackage

/* dv/pgc_core_props.sv */
// Assertions for the playback gain and output control block.
// Bound into pgc_core; watches its ports only, one clock domain.
`timescale 1ns/1ps
module pgc_core_props
  import pgc_pkg::*;
(
  input wire logic                clock_i,
  input wire logic                reset_n_i,
  input wire logic                enable_i,
  input wire logic [ADDR_W-1:0]   addr_i,
  input wire logic [DATA_W-1:0]   wr_data_i,
  input wire logic                wr_i,
  input wire logic                mute_i,
  input wire logic                fs_tick_i,
  input wire logic [VOL_W-1:0]    vol_left_o,
  input wire logic [LIM_W-1:0]    spk_att_o,
  input wire logic [SAMPLE_W-1:0] cap_left_o,
  input wire logic [SAMPLE_W-1:0] cap_right_o,
  input wire logic                right_rec_power_o,
  input wire pgc_amp_ctrl_t       amp_o,
  input wire pgc_switch_t         switch_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  logic [7:0] path_sh;
  logic [7:0] spk_sh;
  logic [1:0] age;
  // Shadow copies of the path and speaker bytes; age waits out the output register stage
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      path_sh <= 8'h00;
      spk_sh  <= 8'h00;
      age     <= 2'h0;
    end else if (enable_i) begin
      if (wr_i && addr_i == ADDR_PATH) path_sh <= wr_data_i;
      if (wr_i && addr_i == ADDR_SPK) spk_sh <= wr_data_i;
      age <= wr_i ? 2'h0 : ((age == 2'h3) ? age : age + 2'h1);
    end
  end
  // Output relations
  AST_MUTE_SW: assert property ((mute_i && enable_i)[*5] |-> switch_o == '0)
    else $error("switches left on under mute");
  AST_MUTE_AMP: assert property ((mute_i && enable_i)[*5] |->
    amp_o.speaker != AMP_ACTIVE && amp_o.line_one != AMP_ACTIVE) else $error("output driven");
  AST_VOL_CAUSE: assert property ($changed(vol_left_o) |->
    $past(fs_tick_i, 2) || $past(wr_i, 2)) else $error("volume moved without cause");
  AST_ATT_UP: assert property (spk_att_o > $past(spk_att_o) |->
    spk_att_o == $past(spk_att_o) + 7'h01 && $past(fs_tick_i, 2)) else $error("bad cut step");
  AST_ATT_DN: assert property (spk_att_o < $past(spk_att_o) |->
    spk_att_o == $past(spk_att_o) - 7'h02 || spk_att_o == 7'h00) else $error("bad gain step");
  AST_SPK_HIZ: assert property (age == 2'h3 && !spk_sh[SPK_POWER] |->
    amp_o.speaker == AMP_HIZ && amp_o.mono_out == AMP_HIZ) else $error("speaker not off");
  AST_SPK_SAVE: assert property (age == 2'h3 && spk_sh[1:0] == 2'b01 |->
    amp_o.speaker == AMP_COMMON) else $error("speaker not in power save");
  AST_HP_LOW: assert property (age == 2'h3 && !spk_sh[SPK_HP_POWER] |->
    amp_o.headphone == AMP_LOW) else $error("headphone not low");
  AST_LINE_HIZ: assert property (age == 2'h3 && !path_sh[PATH_LINE1_PW] |->
    amp_o.line_one == AMP_HIZ) else $error("line output not released");
  AST_MONO_CAP: assert property ($past(fs_tick_i) && !right_rec_power_o &&
    !$past(right_rec_power_o, 2) |-> cap_right_o == cap_left_o) else $error("mono copy wrong");
  CV_MUTE: cover property (mute_i && switch_o == '0);
  CV_LIMIT: cover property (spk_att_o == 7'h0C);
  CV_MONO: cover property (!right_rec_power_o && $past(fs_tick_i));
endmodule // pgc_core_props

bind pgc_core pgc_core_props u_props (.*);

/* dv/pgc_amp_model.sv */
// Model of the analogue amplifiers behind the block's amplifier states.
// Pin codes: 0 low, 1 common level, 2 signal, 3 released.
`timescale 1ns/1ps
module pgc_amp_model
  import pgc_pkg::*;
(
  input  wire pgc_amp_ctrl_t amp_i,
  output logic [9:0]         pins_o
);
  // A bad or unknown state reads as released, never as a drive
  function automatic logic [1:0] pin(input pgc_amp_t a);
    case (a)
      AMP_LOW:    pin = 2'h0;
      AMP_COMMON: pin = 2'h1;
      AMP_ACTIVE: pin = 2'h2;
      default:    pin = 2'h3;
    endcase
  endfunction
  // Line one, line two, headphone, speaker, mono
  assign pins_o = {pin(amp_i.line_one), pin(amp_i.line_two), pin(amp_i.headphone),
                   pin(amp_i.speaker), pin(amp_i.mono_out)};
endmodule // pgc_amp_model

/* dv/pgc_core_tb.sv */
// Self-checking bench for pgc_core with the amplifier model on its outputs.
// Assumes pgc_pkg; the sample strobe comes every fourth clock.
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin error_cnt++; \
  $display("[ERR] %0t got %0h exp %0h", $time, (a), (e)); end end
module pgc_core_tb
  import pgc_pkg::*;
;
  logic                clock_i, reset_n_i, enable_i, wr_i, rd_i, mute_i, rdp;
  logic                fs_tick_i = 1'b0;
  logic                right_rec_power_o;
  logic [ADDR_W-1:0]   addr_i;
  logic [DATA_W-1:0]   wr_data_i, rd_data_o, ex;
  logic [SAMPLE_W-1:0] play_left_i, play_right_i, cap_left_i, cap_right_i;
  logic [SAMPLE_W-1:0] spk_mono_o, cap_left_o, cap_right_o;
  logic [VOL_W-1:0]    vol_left_o, vol_right_o;
  logic [LIM_W-1:0]    spk_att_o;
  logic [1:0]          hp_mix_count_o;
  logic [1:0]          tdiv = 2'h0;
  pgc_amp_ctrl_t       amp_o;
  pgc_switch_t         switch_o;
  logic [9:0]          pins;
  logic [7:0]          exq[$];
  logic signed [16:0]  sum;
  logic [6:0]          codes[4] = '{7'h7F, 7'h57, 7'h01, 7'h00};
  int                  error_cnt = 0, n_compared = 0, cyc = 0, i;

  pgc_core DUT (.*);
  pgc_amp_model u_amp (.amp_i(amp_o), .pins_o(pins));

  // 100 ns clock
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  // Sample strobe, read-data monitor and run limit; the queue keeps reads in order
  always @(posedge clock_i) begin
    tdiv <= tdiv + 2'h1;
    fs_tick_i <= (tdiv == 2'h3);
    rdp <= rd_i;
    if (rdp) begin
      ex = exq.pop_front();
      `CHK(rd_data_o, ex)
    end
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      stop_test();
    end
  end

  task automatic cy(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  // Wait, then sit at the falling edge where outputs have settled
  task automatic st(input int n);
    repeat (n) @(posedge clock_i);
    @(negedge clock_i);
  endtask
  // Bus cycles start at the next edge, so strobes never collide
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clock_i);
    exq.push_back(e);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
  endtask
  // Toggle the left sample every strobe so the mono feed keeps crossing zero
  task automatic swing(input int n);
    repeat (n) begin
      play_left_i <= ~play_left_i;
      cy(4);
    end
  endtask
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Main sequence
  initial begin
    void'($urandom(32'h8F13));
    {reset_n_i, enable_i, wr_i, rd_i, mute_i} = 5'b01000;
    {addr_i, wr_data_i} = '0;
    {play_left_i, play_right_i, cap_left_i, cap_right_i} = '0;
    cy(10);
    reset_n_i <= 1'b1;
    st(2);
    `CHK({amp_o, right_rec_power_o}, {AMP_HIZ, AMP_HIZ, AMP_LOW, AMP_HIZ, AMP_HIZ, 1'b1})
    rd(ADDR_LIMIT, 8'h80);
    rd(4'hF, 8'h00); // Unmapped place reads zero
    for (i = 0; i < 4; i++) begin
      wr(ADDR_VOL_L, {1'b0, codes[i]});
      st(1);
      `CHK(vol_left_o, codes[i])
      rd(ADDR_APPLIED_L, {1'b0, codes[i]});
    end
    // Crossing on the right only; left holds until its 128-sample timeout
    play_left_i <= 16'h0100;
    play_right_i <= 16'h0100;
    wr(ADDR_CTRL, 8'h01);
    wr(ADDR_VOL_L, 8'h0A);
    wr(ADDR_VOL_R, 8'h0A);
    wr(ADDR_VOL_L, 8'h14);
    st(16);
    `CHK({vol_left_o, vol_right_o}, 14'h0000)
    cy(1);
    play_right_i <= 16'hFF00;
    st(12);
    `CHK({vol_left_o, vol_right_o}, {7'h00, 7'h0A})
    st(520);
    `CHK(vol_left_o, 7'h14)
    wr(ADDR_CTRL, 8'h0B);
    wr(ADDR_VOL_L, 8'h1E);
    st(2000);
    `CHK(vol_left_o, 7'h14)
    st(80);
    `CHK(vol_left_o, 7'h1E)
    wr(ADDR_CTRL, 8'h00);
    for (i = 0; i < 4; i++) begin
      play_left_i <= 16'($urandom);
      play_right_i <= 16'($urandom);
      st(8);
      sum = $signed({play_left_i[15], play_left_i}) + $signed({play_right_i[15], play_right_i});
      `CHK(spk_mono_o, sum[16:1])
      cy(1);
    end
    wr(ADDR_CTRL, 8'h10);
    cap_left_i <= 16'($urandom);
    cap_right_i <= 16'($urandom);
    st(8);
    `CHK({right_rec_power_o, cap_right_o}, {1'b0, cap_left_i})
    `CHK(cap_left_o, cap_left_i)
    wr(ADDR_CTRL, 8'h00);
    st(8);
    `CHK({right_rec_power_o, cap_right_o}, {1'b1, cap_right_i})
    // Every path live, then the mute pin, then the power states one by one
    wr(ADDR_SPK, 8'h1F);
    wr(ADDR_PATH, 8'hFF);
    st(2);
    `CHK({switch_o, hp_mix_count_o, pins[5:2]}, {7'h7F, 2'h3, 4'hA})
    cy(1);
    mute_i <= 1'b1;
    st(5);
    `CHK({switch_o, pins[9:8], pins[3:2]}, {7'h00, 2'h1, 2'h1})
    cy(1);
    mute_i <= 1'b0;
    wr(ADDR_PATH, 8'h13);
    st(4);
    `CHK({pins[9:8], hp_mix_count_o}, {2'h3, 2'h1})
    wr(ADDR_PATH, 8'h0C);
    st(2);
    `CHK({pins[9:8], pins[5:4]}, 4'h5)
    wr(ADDR_SPK, 8'h0F);
    st(2);
    `CHK(pins[5:4], 2'h0)
    wr(ADDR_SPK, 8'h00);
    st(2);
    `CHK(pins[3:0], 4'hF)
    wr(ADDR_SPK, 8'h01);
    st(2);
    `CHK(pins[3:2], 2'h1)
    rd(ADDR_SPK, 8'h01);
    // Loud input is ignored during init, then cut in half-decibel steps
    rd(ADDR_LIMIT, 8'h80);
    play_left_i <= 16'h7FFF;
    play_right_i <= 16'h7FFF;
    st(8000);
    `CHK(spk_att_o, 7'h00)
    st(400);
    `CHK(spk_att_o, 7'h0C)
    rd(ADDR_LIMIT, 8'h0C);
    play_right_i <= 16'h0000;
    play_left_i <= 16'h0200;
    swing(1960);
    @(negedge clock_i);
    `CHK(spk_att_o, 7'h0C)
    swing(100);
    @(negedge clock_i);
    `CHK(spk_att_o, 7'h0A)
    // Clock enable low freezes all state, a write included
    cy(1);
    enable_i <= 1'b0;
    wr(ADDR_VOL_L, 8'h05);
    st(4);
    `CHK({vol_left_o, spk_att_o}, {7'h1E, 7'h0A})
    stop_test();
  end
endmodule // pgc_core_tb
